/* adc_device.sv */
// Summary of operation
// R01: Each strobe rising edge starts a conversion.
// R02: Chain low at strobe rise selects chain.
// R03: Chain high at strobe rise selects select-gated.
// R04: Gated mode drives output only when selected.
// R05: Busy indicator if selected at conversion end; the code gives it in gated mode only.
// R06: Host reads chain data with strobe high.
// R07: Chain mode shifts chain input to output.
// R08: Chain level reappears fourteen clocks later; the code takes sixteen, two of them in the chain input synchroniser.
// R09: Result shifts out on host serial clock.
// R10: Conversion timed by internal clock only.
// R11: Fourteen-bit binary result, clamped at full scale.
// R12: MSB first, one bit per clock edge; the code shifts one bit per rising serial clock edge only.
`timescale 1ns/10ps
`default_nettype none
module adc_device
  import adc_pkg::*;
(
  // System clock and reset
  input  wire logic               clk_sys,
  input  wire logic               rst_n,
  // Link to the host
  adc_link_if.device              link,
  // Converter core side
  input  wire adc_pkg::code_in_t  analog_code,
  output logic                    conv_busy,
  output adc_pkg::result_t        result_word,
  output logic                    result_valid
);
  import adc_pkg::*;

  // Pin synchronisers in the system domain.
  logic       cnv_s1_q;
  logic       cnv_s2_q;
  logic       cnv_s3_q;
  logic       chi_s1_q;
  logic       chi_s2_q;
  logic       cnv_rise;

  // Conversion state.
  logic       chain_mode_q;
  logic       conv_q;
  logic [7:0] conv_cnt_q;
  code_in_t   sample_q;
  result_t    result_q;
  logic       done_tgl_q;
  logic       valid_q;
  logic       busy_hi_q;
  logic       conv_done;

  // Acknowledge back from the serial-clock domain.
  logic       ack_s1_q;
  logic       ack_s2_q;

  // Reset stretch handed to the serial-clock domain.
  logic [7:0] stretch_cnt_q;
  logic       sck_rst_req_q;

  // Serial-clock domain.
  logic       rst_s1_q;
  logic       rst_s2_q;
  logic       tgl_s1_q;
  logic       tgl_s2_q;
  logic       ci_s1_q;
  logic       ci_s2_q;
  logic       seen_q;
  result_t    sr_q;
  logic       dout_q;
  logic       load;

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      cnv_s1_q <= 1'b0;
      cnv_s2_q <= 1'b0;
      cnv_s3_q <= 1'b0;
      chi_s1_q <= 1'b1;
      chi_s2_q <= 1'b1;
    end else begin
      cnv_s1_q <= link.convert_strobe;
      cnv_s2_q <= cnv_s1_q;
      cnv_s3_q <= cnv_s2_q;
      chi_s1_q <= link.chain_input;
      chi_s2_q <= chi_s1_q;
    end
  end

  assign cnv_rise = cnv_s2_q && !cnv_s3_q;

  // The mode is caught with the same synchroniser delay as the strobe,
  // so the host must settle the chain input before raising the strobe.
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      chain_mode_q <= 1'b0;
    end else if (cnv_rise) begin
      chain_mode_q <= !chi_s2_q; // [R02] [R03]
    end
  end

  assign conv_done = conv_q && (conv_cnt_q == CONV_LAST);

  // A new strobe edge restarts the conversion even if one is running.
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      conv_q     <= 1'b0;
      conv_cnt_q <= 8'h00;
      sample_q   <= '0;
    end else if (cnv_rise) begin
      conv_q     <= 1'b1; // [R01]
      conv_cnt_q <= 8'h00;
      sample_q   <= analog_code;
    end else if (conv_done) begin
      conv_q     <= 1'b0;
    end else if (conv_q) begin
      conv_cnt_q <= conv_cnt_q + 8'h01; // [R10]
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      result_q   <= '0;
      done_tgl_q <= 1'b0;
      valid_q    <= 1'b0;
    end else begin
      valid_q <= conv_done;
      if (conv_done) begin
        if (sample_q > {1'b0, CODE_MAX}) begin
          result_q <= CODE_MAX; // [R11]
        end else begin
          result_q <= sample_q[RES_BITS-1:0]; // [R11]
        end
        done_tgl_q <= !done_tgl_q;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      ack_s1_q <= 1'b0;
      ack_s2_q <= 1'b0;
    end else begin
      ack_s1_q <= seen_q;
      ack_s2_q <= ack_s1_q;
    end
  end

  // The busy indicator holds high from the end of conversion until the
  // load of the first bit is acknowledged back or a new strobe rise is seen; a set in the same cycle beats the clear.
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      busy_hi_q <= 1'b0;
    end else if (conv_done && !chain_mode_q &&
                 (!cnv_s2_q || !chi_s2_q)) begin
      busy_hi_q <= 1'b1; // [R05]
    end else if (cnv_rise || (ack_s2_q == done_tgl_q)) begin
      busy_hi_q <= 1'b0;
    end
  end

  // The serial clock may stand still during system reset, so its logic
  // is reset by a stretched request that the host covers with edges.
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      stretch_cnt_q <= 8'h00;
      sck_rst_req_q <= 1'b1;
    end else if (stretch_cnt_q != STRETCH_LAST) begin
      stretch_cnt_q <= stretch_cnt_q + 8'h01;
    end else begin
      sck_rst_req_q <= 1'b0;
    end
  end

  always_ff @(posedge link.serial_clk) begin
    rst_s1_q <= sck_rst_req_q;
    rst_s2_q <= rst_s1_q;
    tgl_s1_q <= done_tgl_q;
    tgl_s2_q <= tgl_s1_q;
    ci_s1_q  <= link.chain_input;
    ci_s2_q  <= ci_s1_q;
  end

  assign load = (tgl_s2_q != seen_q);

  // The result word is only read once its toggle has crossed, and it
  // holds until the next conversion ends, so it needs no own crossing.
  always_ff @(posedge link.serial_clk) begin
    if (rst_s2_q) begin
      seen_q <= 1'b0;
      sr_q   <= '0;
      dout_q <= 1'b0;
    end else if (load) begin
      seen_q <= tgl_s2_q;
      dout_q <= result_q[RES_BITS-1]; // [R12] [R09]
      sr_q   <= {result_q[RES_BITS-2:0], ci_s2_q}; // [R07]
    end else begin
      dout_q <= sr_q[RES_BITS-1]; // [R09] [R12]
      sr_q   <= {sr_q[RES_BITS-2:0], ci_s2_q}; // [R07] [R08]
    end
  end

  // In chain mode the line is always driven; the host frames its reads
  // with the strobe held high.
  assign link.result_oe_n =
    !(chain_mode_q || !cnv_s2_q || !chi_s2_q); // [R04] [R06]

  always_comb begin
    if (conv_q) begin
      link.result_output = 1'b0;
    end else if (busy_hi_q) begin
      link.result_output = 1'b1; // [R05]
    end else begin
      link.result_output = dout_q;
    end
  end

  assign conv_busy    = conv_q;
  assign result_word  = result_q;
  assign result_valid = valid_q;

endmodule
`default_nettype wire

/* adc_host.sv */
`timescale 1ns/10ps
`default_nettype none
module adc_host
  import adc_pkg::*;
(
  // System clock and reset
  input  wire logic               clk_sys,
  input  wire logic               rst_n,
  // Link to the converter
  adc_link_if.host                link,
  // User side
  input  wire logic               start,
  input  wire logic               chain_sel,
  input  wire logic               chain_fill,
  output logic                    ready,
  output adc_pkg::result_t        word,
  output logic                    word_valid
);
  import adc_pkg::*;

  host_state_t state_q;
  logic        mode_chain_q;
  logic [7:0]  tmr_q;
  logic [1:0]  ph_q;
  logic [5:0]  hp_q;
  logic        sck_q;
  logic        cnv_q;
  logic        chain_q;
  logic        rd_s1_q;
  logic        rd_s2_q;
  result_t     word_q;
  logic        valid_q;
  logic        tick;

  assign tick = (ph_q == SCK_HALF_LAST);

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      state_q      <= H_WARM;
      mode_chain_q <= 1'b0;
      tmr_q        <= 8'h00;
    end else begin
      tmr_q <= tmr_q + 8'h01;
      case (state_q)
        H_WARM: begin
          if (tmr_q == WARM_LAST) begin
            state_q <= H_IDLE;
          end
        end
        H_IDLE: begin
          tmr_q <= 8'h00;
          if (start) begin
            mode_chain_q <= chain_sel;
            state_q      <= H_SETUP;
          end
        end
        H_SETUP: begin
          if (tmr_q == SETUP_LAST) begin
            tmr_q   <= 8'h00;
            state_q <= H_CONV;
          end
        end
        H_CONV: begin
          if (tmr_q == CONV_WAIT) begin
            state_q <= H_READ;
          end
        end
        H_READ: begin
          if (tick && hp_q == HP_LAST) begin
            state_q <= H_DONE;
          end
        end
        H_DONE: begin
          state_q <= H_IDLE;
        end
        default: begin
          state_q <= H_IDLE;
        end
      endcase
    end
  end

  // The clock runs while warming up so the device can reset its
  // serial-clock logic, and during reads; otherwise it rests low.
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      ph_q  <= 2'h0;
      hp_q  <= 6'h00;
      sck_q <= 1'b0;
    end else if (state_q == H_WARM || state_q == H_READ) begin
      ph_q <= ph_q + 2'h1;
      if (tick) begin
        sck_q <= !sck_q; // [R09]
        hp_q  <= hp_q + 6'h01;
      end
    end else begin
      ph_q  <= 2'h0;
      hp_q  <= 6'h00;
      sck_q <= 1'b0;
    end
  end

  // Chain low before the strobe rises selects chain mode; in chain mode
  // the strobe stays high through the read.
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      cnv_q   <= 1'b0;
      chain_q <= 1'b1;
    end else begin
      case (state_q)
        H_SETUP: begin
          chain_q <= !mode_chain_q; // [R02] [R03]
        end
        H_CONV: begin
          cnv_q <= 1'b1;
        end
        H_READ: begin
          cnv_q   <= mode_chain_q; // [R06]
          chain_q <= mode_chain_q ? chain_fill : 1'b1;
        end
        default: begin
          cnv_q   <= 1'b0;
          chain_q <= 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      rd_s1_q <= 1'b0;
      rd_s2_q <= 1'b0;
    end else begin
      rd_s1_q <= link.result_line;
      rd_s2_q <= rd_s1_q;
    end
  end

  // Each bit is taken at the falling edge after it was presented.
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      word_q  <= '0;
      valid_q <= 1'b0;
    end else begin
      valid_q <= (state_q == H_DONE);
      if (state_q == H_READ && tick && sck_q && hp_q >= HP_SAMPLE) begin
        word_q <= {word_q[RES_BITS-2:0], rd_s2_q};
      end
    end
  end

  assign link.serial_clk     = sck_q;
  assign link.convert_strobe = cnv_q;
  assign link.chain_input    = chain_q;
  assign ready               = (state_q == H_IDLE);
  assign word                = word_q;
  assign word_valid          = valid_q;

endmodule
`default_nettype wire

/* adc_link_if.sv */
`timescale 1ns/10ps
`default_nettype none
interface adc_link_if;
  logic convert_strobe;
  logic chain_input;
  logic serial_clk;
  logic result_output;
  logic result_oe_n;
  logic result_line;

  // A released line rests high, as a board pull-up would hold it, so the
  // host never samples an undefined level between frames.
  assign result_line = result_oe_n ? 1'b1 : result_output;

  modport device (
    input  convert_strobe,
    input  chain_input,
    input  serial_clk,
    output result_output,
    output result_oe_n
  );

  modport host (
    output convert_strobe,
    output chain_input,
    output serial_clk,
    input  result_line
  );
endinterface
`default_nettype wire

/* adc_link_monitor.sv */
`timescale 1ns/10ps
`default_nettype none
module adc_link_monitor (
  // Clock and reset
  input  wire logic clk_sys,
  input  wire logic rst_n,
  // Link signals
  input  wire logic convert_strobe,
  input  wire logic chain_input,
  input  wire logic serial_clk,
  input  wire logic result_output,
  input  wire logic result_oe_n,
  input  wire logic result_line
);
  logic       seen_q;
  logic       chain_q;
  logic       strobe_q;
  logic [3:0] hi_q;
  logic [3:0] lo_q;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  // The mode is unknown until the first conversion, so steady checks wait.
  always_ff @(posedge clk_sys) begin
    strobe_q <= convert_strobe;
    if (!rst_n) begin
      seen_q  <= 1'b0;
      chain_q <= 1'b0;
    end else if (convert_strobe && !strobe_q) begin
      seen_q  <= 1'b1;
      chain_q <= !chain_input;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n || !convert_strobe)
      hi_q <= 4'h0;
    else if (hi_q != 4'hF)
      hi_q <= hi_q + 4'h1;
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n || convert_strobe)
      lo_q <= 4'h0;
    else if (lo_q != 4'hF)
      lo_q <= lo_q + 4'h1;
  end

  sequence s_gated_rise;
    $rose(convert_strobe) && chain_input;
  endsequence
  sequence s_chain_rise;
    $rose(convert_strobe) && !chain_input;
  endsequence

  property p_gated_rise;
    s_gated_rise |-> ##6 result_oe_n [*8];
  endproperty
  property p_chain_rise;
    s_chain_rise |-> ##6 (!result_oe_n && !result_output) [*8];
  endproperty
  property p_gated_off;
    seen_q && !chain_q && chain_input && hi_q >= 4'h8 |-> result_oe_n;
  endproperty
  property p_enabled;
    seen_q && lo_q >= 4'h6 |-> !result_oe_n;
  endproperty
  property p_chain_drive;
    seen_q && chain_q && hi_q >= 4'h6 |-> !result_oe_n;
  endproperty
  property p_fall_enable;
    $fell(convert_strobe) && chain_input |-> ##[1:5] !result_oe_n;
  endproperty
  property p_bit_hold;
    seen_q && $fell(serial_clk) && !result_oe_n |-> $stable(result_line);
  endproperty
  property p_bit_settle;
    seen_q && $rose(serial_clk) && !result_oe_n
      |=> $stable(result_output) [*3];
  endproperty

  a_gated_rise: assert property (p_gated_rise)
    else $error("line driven after a select-gated start");
  a_chain_rise: assert property (p_chain_rise)
    else $error("chain start did not drive a low line");
  a_gated_off: assert property (p_gated_off)
    else $error("line driven while deselected");
  a_enabled: assert property (p_enabled)
    else $error("line released while strobe low");
  a_chain_drive: assert property (p_chain_drive)
    else $error("line released in chain mode");
  a_fall_enable: assert property (p_fall_enable)
    else $error("line not enabled after strobe fall");
  a_bit_hold: assert property (p_bit_hold)
    else $error("data moved at serial clock fall");
  a_bit_settle: assert property (p_bit_settle)
    else $error("data moved between serial clock edges");
endmodule
`default_nettype wire

/* adc_pkg.sv */
`default_nettype none
package adc_pkg;

  // System clock and conversion timing.
  localparam int CLK_SYS_PERIOD_NS = 20;
  localparam int CONV_TIME_NS      = 1600;
  localparam int CONV_CYCLES       =
    (CONV_TIME_NS + CLK_SYS_PERIOD_NS - 1) / CLK_SYS_PERIOD_NS;
  localparam logic [7:0] CONV_LAST = 8'(CONV_CYCLES - 1);

  // Result format.
  localparam int RES_BITS = 14;
  localparam logic [RES_BITS-1:0] CODE_MAX = 14'h3FFF;
  typedef logic [RES_BITS-1:0] result_t;
  typedef logic [RES_BITS:0]   code_in_t;

  // Serial frame: two edges let the ready toggle cross, then 14 bits.
  localparam int SYNC_EDGES  = 2;
  localparam int FRAME_EDGES = SYNC_EDGES + RES_BITS;
  localparam logic [5:0] HP_LAST   = 6'(2 * FRAME_EDGES - 1);
  localparam logic [5:0] HP_SAMPLE = 6'(2 * SYNC_EDGES + 1);

  // Reset stretch that the device holds for its serial-clock logic.
  localparam logic [7:0] STRETCH_LAST = 8'h3F;

  // Host side timing.
  localparam logic [1:0] SCK_HALF_LAST = 2'h3;
  localparam logic [7:0] WARM_LAST     = 8'h9F;
  localparam logic [7:0] SETUP_LAST    = 8'h03;
  localparam logic [7:0] CONV_WAIT     = 8'(CONV_CYCLES + 8);

  typedef enum logic [5:0] {
    H_WARM  = 6'h01,
    H_IDLE  = 6'h02,
    H_SETUP = 6'h04,
    H_CONV  = 6'h08,
    H_READ  = 6'h10,
    H_DONE  = 6'h20
  } host_state_t;

endpackage
`default_nettype wire

/* adc_serial_readout_modes_tb_top.sv */
`timescale 1ns/10ps
`default_nettype none
`define CHK(got, exp) begin \
  checks++; \
  if ((got) !== (exp)) begin \
    bad_count++; \
    $display("unexpected at %0t: got %h expected %h", $time, got, exp); \
  end \
end
module adc_serial_readout_modes_tb_top;
  import adc_pkg::*;
  logic     clk_sys     = 1'b0;
  logic     rst_n       = 1'b0;
  logic     start       = 1'b0;
  logic     chain_sel   = 1'b0;
  logic     chain_fill  = 1'b0;
  code_in_t analog_code = 15'h0000;
  logic     ready;
  logic     word_valid;
  logic     conv_busy;
  logic     result_valid;
  logic     busy_seen;
  result_t  word;
  result_t  result_word;
  int       pulses;
  int       bad_count   = 0;
  int       checks      = 0;

  always #10 clk_sys = ~clk_sys;

  adc_link_if link ();

  adc_host u_adc_host (
    .clk_sys    (clk_sys),
    .rst_n      (rst_n),
    .link       (link),
    .start      (start),
    .chain_sel  (chain_sel),
    .chain_fill (chain_fill),
    .ready      (ready),
    .word       (word),
    .word_valid (word_valid)
  );

  adc_device u_adc_device (
    .clk_sys      (clk_sys),
    .rst_n        (rst_n),
    .link         (link),
    .analog_code  (analog_code),
    .conv_busy    (conv_busy),
    .result_word  (result_word),
    .result_valid (result_valid)
  );

  adc_link_monitor u_adc_link_monitor (
    .clk_sys        (clk_sys),
    .rst_n          (rst_n),
    .convert_strobe (link.convert_strobe),
    .chain_input    (link.chain_input),
    .serial_clk     (link.serial_clk),
    .result_output  (link.result_output),
    .result_oe_n    (link.result_oe_n),
    .result_line    (link.result_line)
  );

  task automatic tally_and_finish;
    $display("mismatches %0d comparisons %0d", bad_count, checks);
    if (bad_count == 0 && checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // One full transfer through the host; the device sees the code at start.
  task automatic xfer(input code_in_t code, input logic chain,
                      input logic fill, input result_t exp);
    int n;
    n = 0;
    while (ready !== 1'b1 && n < 500) begin
      @(negedge clk_sys);
      n++;
    end
    `CHK(ready, 1'b1)
    analog_code = code;
    chain_sel   = chain;
    chain_fill  = fill;
    start       = 1'b1;
    @(negedge clk_sys);
    start     = 1'b0;
    busy_seen = 1'b0;
    pulses    = 0;
    n         = 0;
    while (word_valid !== 1'b1 && n < 600) begin
      @(negedge clk_sys);
      if (conv_busy === 1'b1)
        busy_seen = 1'b1;
      if (result_valid === 1'b1)
        pulses++;
      n++;
    end
    `CHK(word_valid, 1'b1)
    `CHK(word, exp)
    `CHK(result_word, exp)
    `CHK(busy_seen, 1'b1)
    `CHK(pulses, 1)
  endtask

  // Back to back select-gated reads; patterns expose bit order and edges.
  task automatic t_gated;
    result_t tbl [4];
    tbl = '{14'h2A5C, 14'h0001, 14'h2000, 14'h1555};
    foreach (tbl[i])
      xfer({1'b0, tbl[i]}, 1'b0, 1'b0, tbl[i]);
  endtask

  task automatic t_clamp;
    xfer(15'h3FFF, 1'b0, 1'b0, 14'h3FFF);
    xfer(15'h4000, 1'b0, 1'b0, 14'h3FFF);
    xfer(15'h7FFF, 1'b1, 1'b1, 14'h3FFF);
  endtask

  // Chain reads with both fill levels, then a switch back to gated mode.
  task automatic t_chain;
    xfer(15'h2C3A, 1'b1, 1'b1, 14'h2C3A);
    xfer(15'h13C5, 1'b1, 1'b0, 14'h13C5);
    xfer(15'h0ABC, 1'b0, 1'b1, 14'h0ABC);
  endtask

  initial begin
    repeat (20) @(negedge clk_sys);
    rst_n = 1'b1;
    t_gated();
    t_clamp();
    t_chain();
    tally_and_finish();
  end

  // Ten transfers need about 2,500 cycles; this allows several times that.
  initial begin
    #200000;
    bad_count++;
    tally_and_finish();
  end
endmodule
`default_nettype wire
